// [core/icap_consts.svh]
// Purpose: shared constants of the csr access port
// Assumes: included by bare name
// Notes: bank offsets are byte indices on the serial link
`ifndef ICAP_CONSTS_SVH
`define ICAP_CONSTS_SVH
// target bank
`define ICAP_TADDR_HI       6'h16
`define ICAP_OFS_IDENT_LAST 8'h08
`define ICAP_OFS_RESTART    8'h09
`define ICAP_OFS_CLKCFG     8'h0a
`define ICAP_RANGE_RST      3'h5
`define ICAP_SRC_RST        1'h0
// link timing
`define ICAP_BIT_NS         2500
`define ICAP_CLK_NS         10
`define ICAP_QTR_CYC        ((`ICAP_BIT_NS / 4 + `ICAP_CLK_NS - 1) / `ICAP_CLK_NS)
// controller registers
`define ICAP_CSR_CMD        4'h0
`define ICAP_CSR_STAT       4'h4
`define ICAP_CSR_RDATA      4'h8
// command fields
`define ICAP_CB_SUB         8
`define ICAP_CB_RD          16
`define ICAP_CB_HSUB        17
`define ICAP_CB_HDATA       18
`define ICAP_CB_TSEL        19
`define ICAP_CB_CNT         20
`endif

// [core/icap_pkg.sv]
// Purpose: types of the csr access port
// Assumes: nothing
// Notes: state encodings left to the tools
`default_nettype none
package icap_pkg;
  typedef enum logic [2:0] {T_IDLE, T_RX, T_ACKW, T_ACK, T_TX, T_RACK, T_RNEXT} icap_tst_e;
  typedef enum logic [1:0] {PH_ADDR, PH_SUB, PH_DATA} icap_phase_e;
  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} icap_hst_e;
  typedef enum logic [1:0] {K_ADDR, K_SUB, K_WDATA, K_RDATA} icap_kind_e;
endpackage : icap_pkg
`default_nettype wire

// [core/icap_if.sv]
// Purpose: two-wire link between controller and target
// Assumes: open-drain lines with pull-ups
// Notes: an enable high pulls its line to the output value
`timescale 1ns/1ps
`default_nettype none
interface icap_if;
  // drivers
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic t_sda_o;
  logic t_sda_oe;
  // resolved lines
  logic scl;
  logic sda;

  // wired-and with pull-up
  assign scl = ~(m_scl_oe & ~m_scl_o);
  assign sda = ~((m_sda_oe & ~m_sda_o) | (t_sda_oe & ~t_sda_o));

  modport target (input scl, input sda, output t_sda_o, output t_sda_oe);
  modport master (input sda, output m_scl_o, output m_scl_oe, output m_sda_o, output m_sda_oe);
endinterface : icap_if
`default_nettype wire

// [core/icap_target.sv]
// Purpose: two-wire target giving access to the config_status_regs bank
// Assumes: link lines and pins asynchronous to clk
// Notes: restart pulse leaves the bank untouched
// Function
// - bank reachable whatever the video lanes do
// - correct at fast-mode rates, master stays below
// - seven-bit address, low bit from select pin
// - first byte after start is address
// - accept 5a/5b, or 58/59 with pin low
// - ack address, then ack subaddress byte
// - ack every written data byte, stop ends
// - read from zero or last written subaddress; each data byte written or read also steps the pointer on
// - next read byte only after master ack
// - subaddress-only write sets read start
// - every register reachable over link
// - software leaves reserved fields alone
// - offsets zero to eight fixed, read-only
// - restart bit self-clears, reads zero
// - restart resets logic, keeps register values
// - software restarts after configuration changes
// - pll status bit read-only, resets zero
`timescale 1ns/1ps
`default_nettype none
`include "icap_consts.svh"
module icap_target #(
  parameter logic [71:0] IDENT = 72'h99_88_77_66_55_44_33_22_11 // arbitrary values
) (
  // clock and reset
  input  wire logic  clk,
  input  wire logic  rst_n,
  // serial link
  icap_if.target     bus,
  // device pins
  input  wire logic  chip_en,
  input  wire logic  addr_sel,
  input  wire logic  pll_enabled,
  // register outputs
  output logic       restart_q,
  output logic [2:0] clk_range_q,
  output logic       pixel_clock_source_sel_q
);

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers

  logic [4:0] meta_q;
  logic [4:0] sync_q;
  logic       scl_s;
  logic       sda_s;
  logic       en_s;
  logic       sel_s;
  logic       pll_s;
  logic       lrst;

  // two flops on every pin, lines idle high
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_q <= 5'h18;
      sync_q <= 5'h18;
    end
    else
    begin
      meta_q <= {bus.scl, bus.sda, chip_en, addr_sel, pll_enabled};
      sync_q <= meta_q;
    end
  end

  assign scl_s = sync_q[4];
  assign sda_s = sync_q[3];
  assign en_s  = sync_q[2];
  assign sel_s = sync_q[1];
  assign pll_s = sync_q[0];
  // port only alive while enabled, video state plays no part
  assign lrst  = !rst_n || !en_s;

  ////////////////////////////////////////////////////////////////////////
  // line events

  logic scl_p_q;
  logic sda_p_q;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;

  // previous line levels
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      scl_p_q <= 1'h1;
      sda_p_q <= 1'h1;
    end
    else
    begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // edges and start/stop while clock high
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  assign start    = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop     = scl_s & scl_p_q & ~sda_p_q & sda_s;

  ////////////////////////////////////////////////////////////////////////
  // transfer engine

  icap_pkg::icap_tst_e   st_q;
  icap_pkg::icap_phase_e ph_q;
  logic [2:0] cnt_q;
  logic [7:0] rx_q;
  logic [7:0] tx_q;
  logic [7:0] ptr_q;
  logic       rw_q;
  logic       oe_q;
  logic [7:0] rx_byte;
  logic [7:0] rd_byte;
  logic       wr_en;

  assign rx_byte = {rx_q[6:0], sda_s};
  // last data bit of a write byte
  assign wr_en   = (st_q == icap_pkg::T_RX) && scl_rise && (cnt_q == 3'h7) && (ph_q == icap_pkg::PH_DATA);

  // byte framing, ack and read shifting
  always_ff @(posedge clk)
  begin
    if (lrst)
    begin
      st_q  <= icap_pkg::T_IDLE;
      ph_q  <= icap_pkg::PH_ADDR;
      cnt_q <= 3'h0;
      rx_q  <= 8'h00;
      tx_q  <= 8'h00;
      ptr_q <= 8'h00;
      rw_q  <= 1'h0;
      oe_q  <= 1'h0;
    end
    else if (stop)
    begin
      st_q <= icap_pkg::T_IDLE;
      oe_q <= 1'h0;
    end
    else if (start)
    begin
      st_q  <= icap_pkg::T_RX;
      ph_q  <= icap_pkg::PH_ADDR;
      cnt_q <= 3'h0;
      oe_q  <= 1'h0;
    end
    else
    begin
      case (st_q)
        icap_pkg::T_RX:
        begin
          if (scl_rise)
          begin
            rx_q  <= rx_byte;
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == 3'h7)
            begin
              case (ph_q)
                icap_pkg::PH_ADDR:
                begin
                  if (rx_byte[7:1] == {`ICAP_TADDR_HI, sel_s})
                  begin
                    rw_q <= rx_byte[0];
                    st_q <= icap_pkg::T_ACKW;
                  end
                  else
                    st_q <= icap_pkg::T_IDLE;
                end
                icap_pkg::PH_SUB:
                begin
                  ptr_q <= rx_byte;
                  st_q  <= icap_pkg::T_ACKW;
                end
                default:
                begin
                  ptr_q <= ptr_q + 8'h01;
                  st_q  <= icap_pkg::T_ACKW;
                end
              endcase
            end
          end
        end
        icap_pkg::T_ACKW:
        begin
          // pull data low for the ack slot
          if (scl_fall)
          begin
            oe_q <= 1'h1;
            st_q <= icap_pkg::T_ACK;
          end
        end
        icap_pkg::T_ACK:
        begin
          if (scl_fall)
          begin
            cnt_q <= 3'h0;
            if ((ph_q == icap_pkg::PH_ADDR) && rw_q)
            begin
              tx_q <= rd_byte;
              oe_q <= ~rd_byte[7];
              st_q <= icap_pkg::T_TX;
            end
            else
            begin
              oe_q <= 1'h0;
              st_q <= icap_pkg::T_RX;
              ph_q <= (ph_q == icap_pkg::PH_ADDR) ? icap_pkg::PH_SUB : icap_pkg::PH_DATA;
            end
          end
        end
        icap_pkg::T_TX:
        begin
          // msb first, release for master ack after eight bits
          if (scl_fall)
          begin
            if (cnt_q == 3'h7)
            begin
              oe_q  <= 1'h0;
              cnt_q <= 3'h0;
              st_q  <= icap_pkg::T_RACK;
            end
            else
            begin
              tx_q  <= {tx_q[6:0], 1'h0};
              oe_q  <= ~tx_q[6];
              cnt_q <= cnt_q + 3'h1;
            end
          end
        end
        icap_pkg::T_RACK:
        begin
          // ack sends the next byte, nack waits for stop
          if (scl_rise)
          begin
            ptr_q <= ptr_q + 8'h01;
            st_q  <= sda_s ? icap_pkg::T_IDLE : icap_pkg::T_RNEXT;
          end
        end
        icap_pkg::T_RNEXT:
        begin
          if (scl_fall)
          begin
            tx_q <= rd_byte;
            oe_q <= ~rd_byte[7];
            st_q <= icap_pkg::T_TX;
          end
        end
        default:
          st_q <= icap_pkg::T_IDLE;
      endcase
    end
  end

  assign bus.t_sda_o  = 1'h0;
  assign bus.t_sda_oe = oe_q;

  ////////////////////////////////////////////////////////////////////////
  // register bank

  // read view of the bank, unlisted offsets read zero
  always_comb
  begin
    rd_byte = 8'h00;
    if (ptr_q <= `ICAP_OFS_IDENT_LAST)
      rd_byte = IDENT[{ptr_q[3:0], 3'h0} +: 8];
    else if (ptr_q == `ICAP_OFS_CLKCFG)
      rd_byte = {pll_s, 3'h0, clk_range_q, pixel_clock_source_sel_q};
  end

  // writable fields only, ident bytes ignore writes
  always_ff @(posedge clk)
  begin
    if (lrst)
    begin
      restart_q                <= 1'h0;
      clk_range_q              <= `ICAP_RANGE_RST;
      pixel_clock_source_sel_q <= `ICAP_SRC_RST;
    end
    else
    begin
      restart_q <= wr_en && (ptr_q == `ICAP_OFS_RESTART) && rx_byte[0];
      if (wr_en && (ptr_q == `ICAP_OFS_CLKCFG))
      begin
        clk_range_q              <= rx_byte[3:1];
        pixel_clock_source_sel_q <= rx_byte[0];
      end
    end
  end

endmodule : icap_target
`default_nettype wire

// [core/icap_master.sv]
// Purpose: two-wire controller driven from axi4-lite registers
// Assumes: target never stretches the clock
// Notes: one command at a time, bit rate from QTR
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "icap_consts.svh"
module icap_master #(
  parameter int unsigned QTR = `ICAP_QTR_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // serial link
  icap_if.master           bus,
  // axi4-lite write
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite slave

  logic [3:0]  awa_q;
  logic        aw_have_q;
  logic        w_have_q;
  logic [31:0] wd_q;
  logic [3:0]  ws_q;
  logic        do_wr;
  logic        busy;
  logic        nack_q;
  logic [31:0] rdata_q;
  logic [31:0] cmd_q;
  logic        launch_q;

  assign do_wr = aw_have_q && w_have_q && !s_axi_bvalid;

  // write channels in either order, response after both
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_axi_awready <= 1'h0;
      s_axi_wready  <= 1'h0;
      s_axi_bvalid  <= 1'h0;
      s_axi_bresp   <= 2'h0;
      aw_have_q     <= 1'h0;
      w_have_q      <= 1'h0;
      awa_q         <= 4'h0;
      wd_q          <= 32'h0;
      ws_q          <= 4'h0;
    end
    else
    begin
      s_axi_awready <= !aw_have_q && !s_axi_bvalid && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_have_q && !s_axi_bvalid && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'h1;
        awa_q     <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'h1;
        wd_q     <= s_axi_wdata;
        ws_q     <= s_axi_wstrb;
      end
      if (do_wr)
      begin
        aw_have_q    <= 1'h0;
        w_have_q     <= 1'h0;
        s_axi_bvalid <= 1'h1;
        s_axi_bresp  <= (awa_q[3:2] == 2'h3) ? 2'h3 : 2'h0;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'h0;
    end
  end

  // command register per byte lane, locked while busy
  for (genvar i = 0; i < 4; i++)
  begin : g_lane
    always_ff @(posedge clk)
    begin
      if (!rst_n)
        cmd_q[8*i +: 8] <= 8'h00;
      else if (do_wr && (awa_q == `ICAP_CSR_CMD) && !busy && ws_q[i])
        cmd_q[8*i +: 8] <= wd_q[8*i +: 8];
    end
  end

  // command start pulse
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      launch_q <= 1'h0;
    else
      launch_q <= do_wr && (awa_q == `ICAP_CSR_CMD) && !busy;
  end

  // read channel, one cycle answer
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'h0;
      s_axi_rvalid  <= 1'h0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'h0;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'h1;
        s_axi_rresp  <= (s_axi_araddr[3:2] == 2'h3) ? 2'h3 : 2'h0;
        case (s_axi_araddr)
          `ICAP_CSR_CMD:   s_axi_rdata <= cmd_q;
          `ICAP_CSR_STAT:  s_axi_rdata <= {30'h0, nack_q, busy || launch_q};
          `ICAP_CSR_RDATA: s_axi_rdata <= rdata_q;
          default:         s_axi_rdata <= 32'h0;
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bit engine

  icap_pkg::icap_hst_e  hst_q;
  icap_pkg::icap_kind_e kind_q;
  logic [7:0] qcnt_q;
  logic       tick;
  logic [1:0] qph_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic [1:0] left_q;
  logic       scl_oe_q;
  logic       sda_oe_q;
  logic [1:0] sync_q;
  logic       sda_s;

  assign sda_s = sync_q[1];
  assign tick  = (qcnt_q == 8'(QTR - 1));
  assign busy  = (hst_q != icap_pkg::H_IDLE);

  // data line synchroniser
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      sync_q <= 2'h3;
    else
      sync_q <= {sync_q[0], bus.sda};
  end

  // quarter bit timer sets the bit rate
  always_ff @(posedge clk)
  begin
    if (!rst_n || !busy || tick)
      qcnt_q <= 8'h00;
    else
      qcnt_q <= qcnt_q + 8'h01;
  end

  // start, nine-bit bytes, stop
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      hst_q    <= icap_pkg::H_IDLE;
      kind_q   <= icap_pkg::K_ADDR;
      qph_q    <= 2'h0;
      bit_q    <= 4'h0;
      sh_q     <= 8'h00;
      left_q   <= 2'h0;
      scl_oe_q <= 1'h0;
      sda_oe_q <= 1'h0;
      nack_q   <= 1'h0;
      rdata_q  <= 32'h0;
    end
    else if (hst_q == icap_pkg::H_IDLE)
    begin
      if (launch_q)
      begin
        hst_q  <= icap_pkg::H_START;
        kind_q <= icap_pkg::K_ADDR;
        qph_q  <= 2'h0;
        bit_q  <= 4'h0;
        nack_q <= 1'h0;
        left_q <= cmd_q[`ICAP_CB_CNT +: 2];
        sh_q   <= {`ICAP_TADDR_HI, cmd_q[`ICAP_CB_TSEL], cmd_q[`ICAP_CB_RD]};
      end
    end
    else if (tick)
    begin
      qph_q <= qph_q + 2'h1;
      case (hst_q)
        icap_pkg::H_START:
        begin
          if (qph_q == 2'h0)
            sda_oe_q <= 1'h1;
          else
          begin
            scl_oe_q <= 1'h1;
            qph_q    <= 2'h0;
            hst_q    <= icap_pkg::H_BIT;
          end
        end
        icap_pkg::H_BIT:
        begin
          case (qph_q)
            2'h0:
              // ack slot: ack a read byte only if more follow
              if (bit_q == 4'h8)
                sda_oe_q <= (kind_q == icap_pkg::K_RDATA) && (left_q != 2'h0);
              else
                sda_oe_q <= (kind_q != icap_pkg::K_RDATA) && !sh_q[7];
            2'h1:
              scl_oe_q <= 1'h0;
            2'h2:
              if (bit_q == 4'h8)
              begin
                if (kind_q != icap_pkg::K_RDATA && sda_s)
                  nack_q <= 1'h1;
              end
              else
                sh_q <= {sh_q[6:0], sda_s};
            default:
            begin
              scl_oe_q <= 1'h1;
              bit_q    <= bit_q + 4'h1;
              if (bit_q == 4'h8)
              begin
                bit_q <= 4'h0;
                hst_q <= icap_pkg::H_STOP;
                if (nack_q)
                  hst_q <= icap_pkg::H_STOP;
                else if (kind_q == icap_pkg::K_RDATA)
                begin
                  rdata_q <= {rdata_q[23:0], sh_q};
                  left_q  <= left_q - 2'h1;
                  if (left_q != 2'h0)
                    hst_q <= icap_pkg::H_BIT;
                end
                else if (kind_q == icap_pkg::K_ADDR && cmd_q[`ICAP_CB_RD])
                begin
                  kind_q <= icap_pkg::K_RDATA;
                  hst_q  <= icap_pkg::H_BIT;
                end
                else if (kind_q == icap_pkg::K_ADDR && cmd_q[`ICAP_CB_HSUB])
                begin
                  kind_q <= icap_pkg::K_SUB;
                  sh_q   <= cmd_q[`ICAP_CB_SUB +: 8];
                  hst_q  <= icap_pkg::H_BIT;
                end
                else if (kind_q != icap_pkg::K_WDATA && cmd_q[`ICAP_CB_HDATA])
                begin
                  kind_q <= icap_pkg::K_WDATA;
                  sh_q   <= cmd_q[7:0];
                  hst_q  <= icap_pkg::H_BIT;
                end
              end
            end
          endcase
        end
        default:
        begin
          // stop: data low, clock high, data high
          case (qph_q)
            2'h0:    sda_oe_q <= 1'h1;
            2'h1:    scl_oe_q <= 1'h0;
            2'h2:    sda_oe_q <= 1'h0;
            default: hst_q    <= icap_pkg::H_IDLE;
          endcase
        end
      endcase
    end
  end

  assign bus.m_scl_o  = 1'h0;
  assign bus.m_scl_oe = scl_oe_q;
  assign bus.m_sda_o  = 1'h0;
  assign bus.m_sda_oe = sda_oe_q;

endmodule : icap_master
`default_nettype wire

// [tb/icap_checker.sv]
// Purpose: wire-level checks of the two-wire link
// Assumes: controller quarter bit of 8 clocks
// Notes: watches resolved lines and every driver enable
`timescale 1ns/1ps
`default_nettype none
module icap_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link drivers and lines
  input wire logic m_scl_o,
  input wire logic m_scl_oe,
  input wire logic m_sda_o,
  input wire logic m_sda_oe,
  input wire logic t_sda_o,
  input wire logic t_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////
  // start and stop conditions
  sequence s_start;
    scl && $past(scl) && $past(sda) && !sda;
  endsequence
  sequence s_stop;
    scl && $past(scl) && !$past(sda) && sda;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  // properties
  a_tgt_open_drain: assert property (t_sda_oe |-> !t_sda_o)
    else $error("target drives data high");
  a_mst_open_drain: assert property (!(m_sda_oe && m_sda_o) && !(m_scl_oe && m_scl_o))
    else $error("controller drives a line high");
  a_tgt_steady_high: assert property (scl && $past(scl) |-> $stable(t_sda_oe))
    else $error("target data moved with clock high");
  a_start_quiet: assert property (s_start |-> !t_sda_oe)
    else $error("target pulls data at start");
  a_start_clocks: assert property (s_start |-> ##[1:40] !scl)
    else $error("no clock after start");
  a_stop_idle: assert property (s_stop |-> !t_sda_oe [*8])
    else $error("target active after stop");
  a_scl_low_len: assert property ($fell(scl) |-> !scl [*8])
    else $error("clock low phase too short");
  a_scl_high_len: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
  a_ack_bounded: assert property ($rose(t_sda_oe) |-> ##[1:300] !t_sda_oe)
    else $error("target holds data too long");
  a_no_contend: assert property (scl && t_sda_oe |-> !m_sda_oe)
    else $error("both ends pull data with clock high");
endmodule : icap_checker
`default_nettype wire

// [tb/i2c_csr_access_port_bench.sv]
// Purpose: bench joining controller and target over the link
// Assumes: quarter bit of 8 clocks, chip enable high except during reset and the chip enable test
// Notes: a bank model predicts every byte read back
`timescale 1ns/1ps
`default_nettype none
`include "icap_consts.svh"
module i2c_csr_access_port_bench;
  localparam logic [71:0] IDENT = 72'h9a_8b_7c_6d_5e_4f_3a_2b_1c; // arbitrary values
  logic        clk, rst_n, chip_en, addr_sel, pll_enabled, restart_q, src_q, src_m, sel;
  logic [2:0]  clk_range_q, range_m;
  logic [3:0]  awaddr, araddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, seed, st;
  logic [1:0]  bresp, rresp, br;
  logic [7:0]  wire_byte;
  logic        scl_d, sda_d;
  int          fails, samples_checked, pulses, p0, ptr_m, nbits;

  icap_if bus_if ();
  icap_target #(.IDENT(IDENT)) i_icap_target (.clk(clk), .rst_n(rst_n), .bus(bus_if.target),
    .chip_en(chip_en), .addr_sel(addr_sel), .pll_enabled(pll_enabled), .restart_q(restart_q),
    .clk_range_q(clk_range_q), .pixel_clock_source_sel_q(src_q));
  icap_master #(.QTR(8)) i_icap_master (.clk(clk), .rst_n(rst_n), .bus(bus_if.master),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  icap_checker i_icap_checker (.clk(clk), .rst_n(rst_n), .m_scl_o(bus_if.m_scl_o),
    .m_scl_oe(bus_if.m_scl_oe), .m_sda_o(bus_if.m_sda_o), .m_sda_oe(bus_if.m_sda_oe),
    .t_sda_o(bus_if.t_sda_o), .t_sda_oe(bus_if.t_sda_oe), .scl(bus_if.scl), .sda(bus_if.sda));

  ////////////////////////////////////////////////////////////////////////////
  // clock, restart pulse count, first byte after each start
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    if (restart_q === 1'b1)
      pulses++;
    scl_d <= bus_if.scl;
    sda_d <= bus_if.sda;
    if (bus_if.scl && scl_d && sda_d && !bus_if.sda)
      nbits <= 0;
    else if (bus_if.scl && !scl_d && nbits < 8)
    begin
      wire_byte <= {wire_byte[6:0], bus_if.sda};
      nbits     <= nbits + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  function automatic logic [7:0] exp_byte(input int ofs);
    if (ofs <= 8)
      return IDENT[8*ofs +: 8];
    if (ofs == 10)
      return {pll_enabled, 3'h0, range_m, src_m};
    return 8'h00;
  endfunction : exp_byte
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one write, address and data offered together
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge clk);
      if (!aw_ok && awready === 1'b1)
      begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1)
      begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    resp = bresp;
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
    araddr  <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    rready <= 1'b0;
    check({30'h0, rresp}, 32'h0);
  endtask : axi_rd
  // launch a link command, wait for idle
  task automatic run_cmd(input logic [1:0] n, input logic ts, input logic [2:0] kind,
                         input logic [7:0] sub, input logic [7:0] dat);
    axi_wr(`ICAP_CSR_CMD, {10'h0, n, ts, kind, sub, dat}, br);
    check({30'h0, br}, 32'h0);
    do axi_rd(`ICAP_CSR_STAT, st); while (st[0] !== 1'b0);
  endtask : run_cmd
  task automatic wr_reg(input logic [7:0] sub, input logic [7:0] dat);
    run_cmd(2'd0, sel, 3'b110, sub, dat);
    check({31'h0, st[1]}, 32'h0);
    check({24'h0, wire_byte}, sel ? 32'h5a : 32'h58);
    if (sub == 8'h0a)
      {range_m, src_m} = dat[3:0];
    ptr_m = (sub + 1) % 256;
  endtask : wr_reg
  task automatic set_ptr(input logic [7:0] sub);
    run_cmd(2'd0, sel, 3'b010, sub, 8'h00);
    check({31'h0, st[1]}, 32'h0);
    ptr_m = sub;
  endtask : set_ptr
  task automatic rd_chk(input logic [1:0] n);
    logic [31:0] d;
    logic [31:0] e;
    run_cmd(n, sel, 3'b001, 8'h00, 8'h00);
    check({31'h0, st[1]}, 32'h0);
    check({24'h0, wire_byte}, sel ? 32'h5b : 32'h59);
    axi_rd(`ICAP_CSR_RDATA, d);
    e = 32'h0;
    for (int i = 0; i <= n; i++)
    begin
      e = {e[23:0], exp_byte(ptr_m)};
      ptr_m = (ptr_m + 1) % 256;
    end
    check(d & (n == 2'd3 ? 32'hffffffff : (32'h1 << (8 * (n + 1))) - 1), e);
  endtask : rd_chk
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out

  ////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial
  begin
    #500_000;
    fails++;
    close_out();
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    clk = 1'b0;
    seed = 32'h7f8fd379;
    ptr_m = 0;
    sel = 1'b1;
    {range_m, src_m} = {`ICAP_RANGE_RST, `ICAP_SRC_RST};
    {rst_n, chip_en, addr_sel, pll_enabled, awvalid, wvalid, bready, arvalid, rready} <= '0;
    repeat (16) @(posedge clk);
    {rst_n, chip_en, addr_sel} <= {2'h3, sel};
    repeat (4) @(posedge clk);
    rd_chk(2'd3);
    set_ptr(8'h07);
    rd_chk(2'd3);
    check({28'h0, clk_range_q, src_q}, {28'h0, range_m, src_m});
    $display("test defaults done");
    // random clock byte, restart after it
    for (int i = 0; i < 3; i++)
    begin
      seed = lfsr(seed);
      pll_enabled <= seed[8];
      wr_reg(`ICAP_OFS_CLKCFG, {seed[7], 3'h0, seed[3:0]});
      p0 = pulses;
      wr_reg(`ICAP_OFS_RESTART, 8'h01);
      check(pulses - p0, 32'h1);
      wr_reg(`ICAP_OFS_RESTART, 8'h00);
      check(pulses - p0, 32'h1);
      check({28'h0, clk_range_q, src_q}, {28'h0, range_m, src_m});
      set_ptr({4'h0, seed[12:9]});
      rd_chk(seed[17:16]);
    end
    $display("test config done");
    // wrong select bit refused, then pin low
    run_cmd(2'd0, ~sel, 3'b010, 8'h00, 8'h00);
    check({31'h0, st[1]}, 32'h1);
    sel = 1'b0;
    addr_sel <= sel;
    repeat (4) @(posedge clk);
    rd_chk(2'd2);
    $display("test select done");
    // chip enable low restores defaults
    chip_en <= 1'b0;
    repeat (4) @(posedge clk);
    chip_en <= 1'b1;
    repeat (4) @(posedge clk);
    {range_m, src_m} = {`ICAP_RANGE_RST, `ICAP_SRC_RST};
    ptr_m = 0;
    check({28'h0, clk_range_q, src_q}, {28'h0, range_m, src_m});
    rd_chk(2'd1);
    $display("test chip enable done");
    close_out();
  end
endmodule : i2c_csr_access_port_bench
`default_nettype wire
